// file: hw/phy_reference_clock_generation.sv
// Purpose: reference clock division, fallback and MII clock distribution
// Assumes: all inputs synchronous to clock; clocks leave as levels built from enables, rx high 2 of 5 ticks, 20 MHz high 4 of 10 cycles
// Notes:   recovered receive clock arrives as an enable from the recovery loop
`timescale 1ns/1ps

// Summary of operation
// - primary oscillator halved onto 25 MHz output
// - primary oscillator divided by 2.5 gives 20 MHz
// - divide-by-two phase undefined after reset
// - idle 20 MHz input falls back to internal
// - config bit 7 disables 25 MHz output
// - tx clock 25, 2.5 or 10 MHz by mode
// - rx clock is recovered 125 MHz divided by five
// - recovery acquires lock when signal detect rises
// - locked recovery holds last frequency after signal loss
// - recovered clock treated asynchronous to local reference
// - single 25 MHz reference forces 100 Mb/s only
// - 10 Mb/s section runs half or full duplex
module phy_reference_clock_generation
  import phy_clk_pkg::*;
#(
  parameter int unsigned LOCK_CYC = 64
) (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire logic                  ref100Input,
  input  wire logic                  ref20Input,
  input  wire logic                  rxRecoveredTick,
  input  wire logic                  signalDetectIn,
  input  wire logic [7:0]            codingSublayerConfigReg,
  input  wire phy_clk_pkg::mode_cfg_s modeCfg,
  output logic                       ref25Output,
  output logic                       txClk,
  output logic                       rxClk,
  output logic                       ref10Clk,
  output logic                       ref20Fallback,
  output logic                       recoveryLocked,
  output logic                       speed10Enabled,
  output logic                       duplex10Full
);
  import phy_clk_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  oscCnt;
    logic        oscPh;
    logic        ref25;
    logic [2:0]  frac;
    logic [3:0]  ref20Cnt;
    logic        ref20;
    logic        ref20InPrev;
    logic [15:0] idleCnt;
    logic        fallback;
    logic [4:0]  div10Cnt;
    logic        clk10;
    logic [2:0]  rxDivCnt;
    logic        rxOut;
    rec_state_e  rec;
    logic [15:0] lockCnt;
    logic        txOut;
  } state_s;

  state_s q, d;

  localparam logic [15:0] IDLE_LIM  = 16'(REF20_IDLE_CYC);
  localparam logic [15:0] LOCK_LIM  = 16'(LOCK_CYC);
  localparam logic [1:0]  OSC_LAST  = 2'(OSC_CYC / 2 - 1);
  localparam logic [2:0]  FRAC_TOP  = 3'(REF20_NUM);
  localparam logic [2:0]  RX_LAST   = 3'(RXREC_DIV - 1);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // one remainder step of the 2.5 divider: {wrap, next remainder}
  function automatic logic [3:0] frac_step(input logic [2:0] frac);
    logic [3:0] sum;
    sum = {1'b0, frac} + 4'(REF20_DEN);
    if (sum >= {1'b0, FRAC_TOP}) begin
      frac_step = {1'b1, 3'(sum - {1'b0, FRAC_TOP})};
    end else begin
      frac_step = {1'b0, sum[2:0]};
    end
  endfunction : frac_step

  // rising edge of a level against its sample one cycle back
  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur & ~prev;
  endfunction : rise_of

  // single 25 MHz wiring cannot run the 10 Mb/s section
  logic only100;
  assign only100 = modeCfg.singleRef25;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic oscTick;
    logic oscEdge;
    logic ref10Tick;
    logic [4:0] div10Lim;
    logic [3:0] fracNext;
    oscTick   = 1'b0;
    oscEdge   = 1'b0;
    ref10Tick = 1'b0;
    div10Lim  = 5'h0;
    fracNext  = 4'h0;
    d = q;
    // primary oscillator edges every 2 system cycles (50 MHz square)
    if (q.oscCnt == OSC_LAST) begin
      d.oscCnt = 2'h0;
      d.oscPh  = ~q.oscPh;
      oscTick  = ~q.oscPh;
      oscEdge  = 1'b1;
    end else begin
      d.oscCnt = q.oscCnt + 2'h1;
    end
    // halve: toggle on each rising oscillator edge
    if (oscTick) d.ref25 = ~q.ref25;
    // divide by 2.5: both oscillator edges step the remainder, so the
    // 20 MHz half periods alternate 6 and 4 cycles around a 5-cycle mean
    fracNext = frac_step(q.frac);
    if (oscEdge) begin
      d.frac = fracNext[2:0];
      if (fracNext[3]) d.ref20 = ~q.ref20;
    end
    // activity watch on the dedicated 20 MHz input
    // any change restarts the count and wins over a count that just ran out
    d.ref20InPrev = ref20Input;
    if (ref20Input != q.ref20InPrev) begin
      d.idleCnt  = 16'h0;
      d.fallback = 1'b0;
    end else if (q.idleCnt != IDLE_LIM) begin
      d.idleCnt = q.idleCnt + 16'h1;
    end else begin
      d.fallback = 1'b1;
    end
    // 10 Mb/s module reference: selected 20 MHz edge
    // internal edge taken from d so the tick lines up with its own toggle
    ref10Tick = q.fallback ? rise_of(d.ref20, q.ref20) : rise_of(ref20Input, q.ref20InPrev);
    // 10 MHz serial or 2.5 MHz nibble from the 20 MHz reference
    div10Lim = modeCfg.serial10 ? 5'h0 : 5'h3;
    if (ref10Tick) begin
      if (q.div10Cnt >= div10Lim) begin
        d.div10Cnt = 5'h0;
        d.clk10    = ~q.clk10;
      end else begin
        d.div10Cnt = q.div10Cnt + 5'h1;
      end
    end
    // recovered 125 MHz ticks divided by five into 25 MHz, own clocking domain in silicon
    // no handshake here: the tick already arrives as a system-clock enable
    if (rxRecoveredTick) begin
      if (q.rxDivCnt == RX_LAST) begin
        d.rxDivCnt = 3'h0;
        d.rxOut    = 1'b1;
      end else begin
        d.rxDivCnt = q.rxDivCnt + 3'h1;
        if (q.rxDivCnt == 3'h1) d.rxOut = 1'b0;
      end
    end
    // recovery lock tracking
    // a loss during acquire falls back to free-run; only a finished lock is held
    case (q.rec)
      REC_FREE: begin
        if (signalDetectIn) begin
          d.rec     = REC_ACQUIRE;
          d.lockCnt = 16'h0;
        end
      end
      REC_ACQUIRE: begin
        if (!signalDetectIn) d.rec = REC_FREE;
        else if (q.lockCnt == LOCK_LIM) d.rec = REC_LOCKED;
        else d.lockCnt = q.lockCnt + 16'h1;
      end
      REC_LOCKED: begin
        if (!signalDetectIn) d.rec = REC_HOLD;
      end
      REC_HOLD: begin
        if (signalDetectIn) begin
          d.rec     = REC_ACQUIRE;
          d.lockCnt = 16'h0;
        end
      end
      default: d.rec = REC_FREE;
    endcase
    // tx clock mux; 100 Mb/s follows the looped-back reference input
    // serial and nibble share one divider, so a mode change may stretch one half period
    d.txOut = (modeCfg.speed100 || only100) ? ref100Input : q.clk10;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // ref25 is given a reset value only to keep simulation clean; users must not
  // rely on its phase against the oscillator
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q          <= '0;
      q.oscCnt   <= OSC_CNT_RST[1:0];
      q.rec      <= REC_FREE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // gate is combinational so a disable takes effect at once
  assign ref25Output    = q.ref25 & ~codingSublayerConfigReg[CFG_REF25_DIS_BIT];
  assign txClk          = q.txOut;
  assign rxClk          = q.rxOut;
  assign ref10Clk       = q.fallback ? q.ref20 : q.ref20InPrev;
  assign ref20Fallback  = q.fallback;
  assign recoveryLocked = (q.rec == REC_LOCKED) || (q.rec == REC_HOLD);
  assign speed10Enabled = ~only100;
  assign duplex10Full   = modeCfg.fullDuplex & ~only100;

endmodule : phy_reference_clock_generation

// file: hw/phy_clk_pkg.sv
// Purpose: shared constants and carriers for the reference clock generation block
// Assumes: one 200 MHz system clock, all rates made as one-cycle enables
// Notes:   primary oscillator modelled as a 50 MHz enable
package phy_clk_pkg;

  // ---------------------------------------------------------------
  // clock rates
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned OSC_MHZ          = 50;
  localparam int unsigned REF25_DIV        = 2;     // primary osc halved
  localparam int unsigned REF20_NUM        = 5;     // divide by 2.5 = 2 toggles per 5 osc edges
  localparam int unsigned REF20_DEN        = 2;
  localparam int unsigned OSC_CYC          = CLK_MHZ / OSC_MHZ;       // 4
  localparam int unsigned REF20_CYC        = 10;    // 200 MHz / 20 MHz
  localparam int unsigned RXREC_DIV        = 5;     // 125 MHz recovered -> 25 MHz
  // idle window on the 20 MHz input before falling back, in ns
  localparam int unsigned REF20_IDLE_NS    = 1000;
  localparam int unsigned REF20_IDLE_CYC   = (REF20_IDLE_NS * CLK_MHZ) / 1000;

  // ---------------------------------------------------------------
  // coding-sublayer configuration bit (pin-level here)
  // ---------------------------------------------------------------
  localparam int unsigned CFG_REF25_DIS_BIT = 7;
  localparam logic [7:0]  CFG_ADDR          = 8'h17;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0]  OSC_CNT_RST      = 3'h0;

  typedef enum logic [1:0] {
    SPEED100_NIBBLE,
    SPEED10_NIBBLE,
    SPEED10_SERIAL
  } mii_mode_e;

  typedef enum logic [1:0] {
    REC_FREE,
    REC_ACQUIRE,
    REC_LOCKED,
    REC_HOLD
  } rec_state_e;

  typedef struct packed {
    logic       speed100;
    logic       serial10;
    logic       fullDuplex;
    logic       singleRef25;
  } mode_cfg_s;

  typedef struct packed {
    logic       txClk;
    logic       rxClk;
    logic       ref25Out;
    logic       ref10Clk;
  } clk_out_s;

endpackage : phy_clk_pkg

// file: tb/mac_clock_monitor.sv
// Purpose: MAC-side model counting rises of the tx and rx clocks
// Assumes: clocks arrive as levels sampled on the system clock
// Notes:   windows stay short, so counts never wrap
`timescale 1ns/1ps
module mac_clock_monitor (
  input  wire logic        clock,
  input  wire logic        clear,
  input  wire logic        txClk,
  input  wire logic        rxClk,
  output logic      [15:0] txRises,
  output logic      [15:0] rxRises
);
  logic txPrev_q;
  logic rxPrev_q;
  always_ff @(posedge clock) begin
    txPrev_q <= txClk;
    rxPrev_q <= rxClk;
    txRises  <= clear ? 16'h0000 : txRises + 16'(txClk & ~txPrev_q);
    rxRises  <= clear ? 16'h0000 : rxRises + 16'(rxClk & ~rxPrev_q);
  end
endmodule : mac_clock_monitor

// file: tb/phy_clk_properties.sv
// Purpose: port checks for reference clock generation
// Assumes: one clock domain, LOCK_CYC handed on by bind
// Notes:   idle and lock bounds carry slack for one-cycle doubt
`timescale 1ns/1ps
module phy_clk_checker #(
  parameter int unsigned LOCK_CYC = 64
) (
  input wire logic                  clock,
  input wire logic                  reset_n,
  input wire logic                  ref100Input,
  input wire logic                  ref20Input,
  input wire logic                  rxRecoveredTick,
  input wire logic                  signalDetectIn,
  input wire logic [7:0]            codingSublayerConfigReg,
  input wire phy_clk_pkg::mode_cfg_s modeCfg,
  input wire logic                  ref25Output,
  input wire logic                  txClk,
  input wire logic                  rxClk,
  input wire logic                  ref20Fallback,
  input wire logic                  recoveryLocked,
  input wire logic                  speed10Enabled,
  input wire logic                  duplex10Full
);
  import phy_clk_pkg::*;
  logic [8:0] idleCnt_q;
  logic [7:0] sdCnt_q;
  logic       ref20Prev_q;
  wire        off  = codingSublayerConfigReg[7];
  wire        m100 = modeCfg.speed100 | modeCfg.singleRef25;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      idleCnt_q   <= 9'h000;
      sdCnt_q     <= 8'h00;
      ref20Prev_q <= 1'b0;
    end else begin
      ref20Prev_q <= ref20Input;
      idleCnt_q   <= (ref20Input != ref20Prev_q) ? 9'h000 : idleCnt_q + 9'(idleCnt_q != 9'h1ff);
      sdCnt_q     <= signalDetectIn ? sdCnt_q + 8'(sdCnt_q != 8'hff) : 8'h00;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  AST_REF25_OFF: assert property (off |-> !ref25Output)
    else $error("ref25 output active while disabled");
  AST_REF25_HALF: assert property (!off && !$past(off) && $changed(ref25Output) |=> (off || $stable(ref25Output))[*3])
    else $error("ref25 half period not four cycles");
  AST_TX_FOLLOW: assert property (m100 && $past(m100) && $past(reset_n) |-> txClk == $past(ref100Input))
    else $error("tx clock not following 100M reference");
  AST_FALLBACK_SET: assert property (idleCnt_q > 9'h0ce |-> ref20Fallback)
    else $error("no fallback on idle 20M input");
  AST_FALLBACK_CLR: assert property (idleCnt_q < 9'h0c3 |-> !ref20Fallback)
    else $error("fallback while 20M input active");
  AST_NO_EARLY_LOCK: assert property (sdCnt_q != 8'h00 && sdCnt_q <= LOCK_CYC |-> !recoveryLocked)
    else $error("lock reported too early");
  AST_NO_LOCK_IDLE: assert property (!signalDetectIn && !recoveryLocked |=> !recoveryLocked)
    else $error("lock without signal detect");
  AST_LOCK_BOUND: assert property (sdCnt_q == LOCK_CYC + 6 |-> recoveryLocked)
    else $error("lock not reached in time");
  AST_HOLD: assert property (recoveryLocked && !signalDetectIn |=> recoveryLocked)
    else $error("lock dropped after signal loss");
  AST_NO_SPEED10: assert property (modeCfg.singleRef25 |-> !speed10Enabled && !duplex10Full)
    else $error("10M section alive on single reference");
  AST_DUPLEX: assert property (!modeCfg.singleRef25 |-> speed10Enabled && duplex10Full == modeCfg.fullDuplex)
    else $error("duplex mode mismatch");
  AST_RX_ON_TICK: assert property ($changed(rxClk) |-> $past(rxRecoveredTick))
    else $error("rx clock moved without recovered tick");
endmodule : phy_clk_checker
bind phy_reference_clock_generation phy_clk_checker #(.LOCK_CYC(LOCK_CYC)) chk (.clock, .reset_n,
  .ref100Input, .ref20Input, .rxRecoveredTick, .signalDetectIn, .codingSublayerConfigReg, .modeCfg,
  .ref25Output, .txClk, .rxClk, .ref20Fallback, .recoveryLocked, .speed10Enabled, .duplex10Full);

// file: tb/phy_reference_clock_generation_tb.sv
// Purpose: self-checking bench for reference clock generation
// Assumes: inputs driven on falling edges, 200 MHz clock
// Notes:   rate windows allow one edge of phase slack
`timescale 1ns/1ps
module phy_reference_clock_generation_tb;
  import phy_clk_pkg::*;
  localparam int unsigned LOCKN = 4;
  logic clock = 0, reset_n = 0, ref100Input = 0, ref20Input = 0, rxRecoveredTick = 0, signalDetectIn = 0;
  logic [7:0] codingSublayerConfigReg = 8'h00;
  mode_cfg_s modeCfg = mode_cfg_s'(4'h8);
  logic ref25Output, txClk, rxClk, ref20Fallback, recoveryLocked, speed10Enabled, duplex10Full;
  logic [15:0] txRises, rxRises, ref10Rises;
  logic ref10Clk, ref10Prev_q;
  logic clear = 1, run20 = 1, runTick = 0, loop = 1;
  int bad_count = 0, checks = 0, cyc = 0, ph = 0;
  always #2.5 clock = ~clock;
  phy_reference_clock_generation #(.LOCK_CYC(LOCKN)) uut (.clock, .reset_n, .ref100Input, .ref20Input,
    .rxRecoveredTick, .signalDetectIn, .codingSublayerConfigReg, .modeCfg, .ref25Output, .txClk, .rxClk,
    .ref10Clk, .ref20Fallback, .recoveryLocked, .speed10Enabled, .duplex10Full);
  mac_clock_monitor mac (.clock, .clear, .txClk, .rxClk, .txRises, .rxRises);
  always @(negedge clock) begin
    ph = (ph == 4) ? 0 : ph + 1;
    if (run20 && ph == 0) ref20Input <= ~ref20Input;
    if (loop) ref100Input <= ref25Output;
    rxRecoveredTick <= runTick & ~rxRecoveredTick;
  end
  always @(posedge clock) begin
    ref10Prev_q <= ref10Clk;
    ref10Rises  <= clear ? 16'h0000 : ref10Rises + 16'(ref10Clk & ~ref10Prev_q);
    cyc++;
    if (cyc == 10000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic wait_n(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_n
  task automatic chk(input logic [15:0] got, input int lo, input int hi, input string msg);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("wrong value t=%0t %s got %0d", $time, msg, got);
    end
  endtask : chk
  task automatic rate(input int n);
    clear = 1;
    wait_n(1);
    clear = 0;
    wait_n(n);
  endtask : rate
  task automatic t_ref100;
    rate(80);
    chk(txRises, 9, 11, "tx 25M");
    codingSublayerConfigReg = 8'h80;
    rate(80);
    chk({15'h0, ref25Output}, 0, 0, "ref25 off");
    chk(txRises, 0, 0, "tx gated");
    codingSublayerConfigReg = 8'h00;
    modeCfg = mode_cfg_s'(4'h1);
    rate(80);
    chk(txRises, 9, 11, "single ref tx");
  endtask : t_ref100
  task automatic t_duplex;
    int e;
    for (int i = 0; i < 4; i++) begin
      modeCfg = mode_cfg_s'(4'(i));
      e = i[0] ? 0 : 2 + i[1];
      wait_n(1);
      chk({14'h0, speed10Enabled, duplex10Full}, e, e, "duplex");
    end
  endtask : t_duplex
  task automatic t_tx10;
    loop = 0;
    modeCfg = mode_cfg_s'(4'h4);
    rate(400);
    chk(txRises, 19, 21, "serial 10M");
    chk(ref10Rises, 39, 41, "external ref10");
    chk({15'h0, ref20Fallback}, 0, 0, "external 20M");
    modeCfg = mode_cfg_s'(4'h0);
    rate(400);
    chk(txRises, 4, 6, "nibble 2.5M");
    run20 = 0;
    rate(260);
    chk({15'h0, ref20Fallback}, 1, 1, "fallback");
    modeCfg = mode_cfg_s'(4'h4);
    rate(200);
    chk(txRises, 9, 11, "internal 20M");
    chk(ref10Rises, 19, 21, "internal ref10");
    run20 = 1;
    wait_n(8);
    chk({15'h0, ref20Fallback}, 0, 0, "fallback clear");
  endtask : t_tx10
  task automatic t_rx;
    runTick = 1;
    rate(100);
    chk(rxRises, 9, 11, "rx 25M");
    runTick = 0;
  endtask : t_rx
  task automatic t_lock;
    signalDetectIn = 1;
    wait_n(LOCKN - 1);
    chk({15'h0, recoveryLocked}, 0, 0, "early lock");
    wait_n(8);
    chk({15'h0, recoveryLocked}, 1, 1, "locked");
    signalDetectIn = 0;
    wait_n(20);
    chk({15'h0, recoveryLocked}, 1, 1, "hold");
    signalDetectIn = 1;
    wait_n(2);
    chk({15'h0, recoveryLocked}, 0, 0, "reacquire");
    signalDetectIn = 0;
    wait_n(2);
    chk({15'h0, recoveryLocked}, 0, 0, "free");
  endtask : t_lock
  initial begin
    wait_n(2);
    reset_n = 1;
    t_ref100();
    t_duplex();
    t_tx10();
    t_rx();
    t_lock();
    final_report();
  end
endmodule : phy_reference_clock_generation_tb
